// [verilog/nci_map.svh]
`ifndef NCI_MAP_SVH
`define NCI_MAP_SVH

// Fixed opcodes and match patterns
`define NCI_OP_EN_INT   16'h50e0
`define NCI_OP_HOLD     16'h0040
`define NCI_INC_MASK    16'hff80
`define NCI_INC_VAL     16'h4a00
`define NCI_JB_MASK     16'hf800
`define NCI_JB0_VAL     16'h8000
`define NCI_JB1_VAL     16'h9000

// Operand field positions
`define NCI_INC_ADDR_LSB 0
`define NCI_JMP_TGT_LSB  0

// Reset values
`define NCI_RST_PC      11'h000
`define NCI_RST_NIB     4'h0
`define NCI_RST_WORD    16'h0000

`endif

// [verilog/nci_pkg.sv]
package nci_pkg;

  // Operating mode of the core
  typedef enum logic [1:0] {
    NCI_RUN,
    NCI_HOLD,
    NCI_ISR
  } nci_mode_t;

  // Arithmetic status flags
  typedef struct packed {
    logic carry;
    logic zero;
  } nci_flags_t;

  // Decoded instruction class
  typedef struct packed {
    logic enInt;
    logic hold;
    logic inc;
    logic jb0;
    logic jb1;
  } nci_dec_t;

endpackage : nci_pkg

// [verilog/nci_dmem.sv]
module nci_dmem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 4
) (
  input  wire logic              clock,
  input  wire logic              rdEn,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData
);

  if (ADDR_W < 1 || DATA_W < 1) begin : g_chk
    $error("nci_dmem: widths must be positive");
  end

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Write port and registered read port
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : nci_dmem

// [verilog/nci_instr_exec.sv]
`include "nci_map.svh"

// Operation
// - Enable-interrupt opcode lets interrupts be accepted
// - Wait opcode enters low-power mode, halting execution
// - Leave wait on interrupt or selected release
// - Interrupt from wait returns to wait
// - Increment nibble into memory, accumulator, flags
// - Untaken bit jump just advances counter
module nci_instr_exec
  import nci_pkg::*;
#(
  parameter int PC_W   = 11,
  parameter int ADDR_W = 7,
  parameter int NIB_W  = 4,
  parameter int EXIT_W = 4
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [15:0]       instrWord,
  input  wire logic              instrValid,
  output logic                   instrReady,
  input  wire logic              intRequest,
  output logic                   intAck,
  input  wire logic              returnDone,
  input  wire logic [EXIT_W-1:0] waitExitEnableBits,
  input  wire logic [EXIT_W-1:0] waitExitEvents,
  output logic [PC_W-1:0]        programCounter,
  output logic [NIB_W-1:0]       accumulator,
  output nci_flags_t             flags,
  output logic                   intEnabled,
  output logic                   waitMode,
  output logic                   foreignInstr
);

  // Elaboration checks on field widths
  if (PC_W != 11 || ADDR_W != 7 || NIB_W != 4 || EXIT_W < 1) begin : g_chk
    $error("nci_instr_exec: unsupported parameter values");
  end

  logic [15:0]       instr_r;
  logic              execPending_r;
  logic              instrReady_r;
  logic              instrReady_nxt;
  nci_mode_t         mode_r;
  nci_mode_t         mode_nxt;
  logic [PC_W-1:0]   pc_r;
  logic [PC_W-1:0]   pc_nxt;
  logic [NIB_W-1:0]  acc_r;
  logic [NIB_W-1:0]  acc_nxt;
  nci_flags_t        flags_r;
  nci_flags_t        flags_nxt;
  logic              intEn_r;
  logic              intEn_nxt;
  logic              intAck_r;
  logic              foreign_r;
  logic              foreign_nxt;
  logic              waitMode_r;

  // Instruction handshake and decode of the instruction in execution
  wire               accept     = instrValid && instrReady_r;
  wire               execNow    = execPending_r;
  wire               isEnInt    = (instr_r == `NCI_OP_EN_INT);
  wire               isHold     = (instr_r == `NCI_OP_HOLD);
  wire               isInc      = ((instr_r & `NCI_INC_MASK) == `NCI_INC_VAL);
  wire               isJb0      = ((instr_r & `NCI_JB_MASK) == `NCI_JB0_VAL);
  wire               isJb1      = ((instr_r & `NCI_JB_MASK) == `NCI_JB1_VAL);
  wire nci_dec_t     dec        = {isEnInt, isHold, isInc, isJb0, isJb1};
  wire               known      = |dec;

  // Operand fields
  wire [ADDR_W-1:0]  incAddr    = instr_r[`NCI_INC_ADDR_LSB +: ADDR_W];
  wire [ADDR_W-1:0]  fetchAddr  = instrWord[`NCI_INC_ADDR_LSB +: ADDR_W];
  wire [PC_W-1:0]    jmpTarget  = instr_r[`NCI_JMP_TGT_LSB +: PC_W];

  // Data memory operand and increment result
  logic [NIB_W-1:0]  memRdData;
  wire [NIB_W:0]     incSum     = {1'b0, memRdData} + {{NIB_W{1'b0}}, 1'b1};
  wire [NIB_W-1:0]   incNib     = incSum[NIB_W-1:0];
  wire               incWr      = execNow && dec.inc;

  // Bit-conditional jump decision
  wire               jumpTaken  = (dec.jb0 && acc_r[0])
                               || (dec.jb1 && acc_r[1]);
  wire [PC_W-1:0]    pcInc      = pc_r + {{(PC_W-1){1'b0}}, 1'b1};

  // Interrupt acceptance at an instruction boundary
  wire               intTake    = intEn_r && intRequest && !execNow;
  wire               exitMatch  = |(waitExitEnableBits & waitExitEvents);

  nci_dmem #(
    .ADDR_W (ADDR_W),
    .DATA_W (NIB_W)
  ) u_dmem (
    .clock  (clock),
    .rdEn   (accept),
    .rdAddr (fetchAddr),
    .rdData (memRdData),
    .wrEn   (incWr),
    .wrAddr (incAddr),
    .wrData (incNib)
  );

  // Program counter next value
  always_comb begin
    pc_nxt = pc_r;
    if (execNow) begin
      if (jumpTaken) begin
        pc_nxt = jmpTarget;
      end else begin
        pc_nxt = pcInc;
      end
    end
  end

  // Accumulator, flags and interrupt enable next values
  always_comb begin
    acc_nxt     = acc_r;
    flags_nxt   = flags_r;
    intEn_nxt   = intEn_r;
    foreign_nxt = 1'b0;
    if (execNow) begin
      foreign_nxt = !known;
      if (dec.inc) begin
        acc_nxt         = incNib;
        flags_nxt.carry = incSum[NIB_W];
        flags_nxt.zero  = (incNib == {NIB_W{1'b0}});
      end
      if (dec.enInt) begin
        intEn_nxt = 1'b1;
      end
    end
  end

  // Mode sequencing for the wait state
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      NCI_RUN: begin
        if (execNow && dec.hold) begin
          mode_nxt = NCI_HOLD;
        end
      end
      NCI_HOLD: begin
        if (intTake) begin
          mode_nxt = NCI_ISR;
        end else if (exitMatch) begin
          mode_nxt = NCI_RUN;
        end
      end
      NCI_ISR: begin
        if (execNow && dec.hold) begin
          mode_nxt = NCI_HOLD;
        end else if (returnDone) begin
          mode_nxt = NCI_HOLD;
        end
      end
      default: begin
        mode_nxt = NCI_RUN;
      end
    endcase
  end

  // Wait state decided for the next cycle
  wire               holdNext   = (mode_nxt == NCI_HOLD);

  // One instruction in flight; no fetch while waiting
  assign instrReady_nxt = !accept && !holdNext;

  // Pipeline control registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      instr_r       <= `NCI_RST_WORD;
      execPending_r <= 1'b0;
      instrReady_r  <= 1'b0;
      mode_r        <= NCI_RUN;
      waitMode_r    <= 1'b0;
    end else begin
      if (accept) begin
        instr_r <= instrWord;
      end
      execPending_r <= accept;
      instrReady_r  <= instrReady_nxt;
      mode_r        <= mode_nxt;
      waitMode_r    <= holdNext;
    end
  end

  // Architectural state registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc_r      <= `NCI_RST_PC;
      acc_r     <= `NCI_RST_NIB;
      flags_r   <= '0;
      intEn_r   <= 1'b0;
      intAck_r  <= 1'b0;
      foreign_r <= 1'b0;
    end else begin
      pc_r      <= pc_nxt;
      acc_r     <= acc_nxt;
      flags_r   <= flags_nxt;
      intEn_r   <= intEn_nxt;
      intAck_r  <= intTake;
      foreign_r <= foreign_nxt;
    end
  end

  // Outputs straight from registers
  assign instrReady     = instrReady_r;
  assign intAck         = intAck_r;
  assign programCounter = pc_r;
  assign accumulator    = acc_r;
  assign flags          = flags_r;
  assign intEnabled     = intEn_r;
  assign waitMode       = waitMode_r;
  assign foreignInstr   = foreign_r;

endmodule : nci_instr_exec

// [test/nci_instr_exec_properties.sv]
`include "nci_map.svh"

module nci_instr_exec_properties
  import nci_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [15:0] instrWord,
  input wire logic       instrValid,
  input wire logic       instrReady,
  input wire logic       intRequest,
  input wire logic       intAck,
  input wire logic       returnDone,
  input wire logic       intEnabled,
  input wire logic       waitMode,
  input wire logic [3:0] waitExitEnableBits,
  input wire logic [3:0] waitExitEvents,
  input wire logic [10:0] programCounter,
  input wire logic [3:0] accumulator,
  input nci_flags_t      flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Take and release decode
  wire       take = instrValid && instrReady;
  wire [4:0] op   = instrWord[15:11];
  wire       rel  = |(waitExitEnableBits & waitExitEvents);
  wire       irq  = intRequest && intEnabled;

  // Interrupt entered from wait, open until return or wait again
  logic      waitLast_r;
  logic      fromWait_r;
  always_ff @(posedge clock) begin
    waitLast_r <= waitMode;
    if (sys_rst) begin
      fromWait_r <= 1'b0;
    end else if (intAck && waitLast_r && !waitMode) begin
      fromWait_r <= 1'b1;
    end else if (returnDone || waitMode) begin
      fromWait_r <= 1'b0;
    end
  end

  a_take_gap: assert property (take |=> !instrReady)
    else $error("ready right after take");
  a_en_int: assert property (take && instrWord == `NCI_OP_EN_INT |=> ##1 intEnabled)
    else $error("interrupts not enabled");
  a_hold_enter: assert property (take && instrWord == `NCI_OP_HOLD |=> ##1 waitMode)
    else $error("wait not entered");
  a_wait_ready: assert property (waitMode |-> !instrReady)
    else $error("ready while waiting");
  a_wait_stay: assert property (waitMode && !irq && !rel |=> waitMode)
    else $error("wait left without cause");
  a_wait_wake: assert property (waitMode && (irq || rel) |=> !waitMode)
    else $error("wait not left");
  a_inc_zero: assert property ((take && (instrWord & `NCI_INC_MASK) == `NCI_INC_VAL)
    |=> ##1 flags.zero == (accumulator == 4'h0))
    else $error("zero flag wrong");
  a_jb0_jump: assert property (take && op == 5'h10 && accumulator[0]
    |=> ##1 programCounter == $past(instrWord[10:0], 2))
    else $error("bit0 jump missed");
  a_jb1_jump: assert property (take && op == 5'h12 && accumulator[1]
    |=> ##1 programCounter == $past(instrWord[10:0], 2))
    else $error("bit1 jump missed");
  a_jb_skip: assert property (take && op == 5'h10 && !accumulator[0]
    |=> ##1 programCounter == $past(programCounter, 2) + 11'h001)
    else $error("untaken jump wrong");
  a_jb1_skip: assert property (take && op == 5'h12 && !accumulator[1]
    |=> ##1 programCounter == $past(programCounter, 2) + 11'h001)
    else $error("untaken bit1 jump wrong");
  a_inc_carry: assert property ((take && (instrWord & `NCI_INC_MASK) == `NCI_INC_VAL)
    |=> ##1 flags.carry == flags.zero)
    else $error("carry flag wrong");
  a_ack_gate: assert property (!intEnabled |=> !intAck)
    else $error("interrupt taken while disabled");
  a_ret_wait: assert property (fromWait_r && !waitMode && returnDone |=> waitMode)
    else $error("wait not resumed after return");
endmodule : nci_instr_exec_properties

bind nci_instr_exec nci_instr_exec_properties nci_instr_exec_properties_i (
  .clock, .sys_rst, .instrWord, .instrValid, .instrReady, .intRequest, .intAck, .returnDone,
  .intEnabled, .waitMode, .waitExitEnableBits, .waitExitEvents, .programCounter,
  .accumulator, .flags);

// [test/tb_top.sv]
`include "nci_map.svh"

module tb_top
  import nci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, sys_rst, instrValid, intRequest, returnDone;
  logic [15:0] instrWord;
  logic [3:0]  waitExitEnableBits, waitExitEvents;
  wire         instrReady, intAck, intEnabled, waitMode, foreignInstr;
  wire [10:0]  programCounter;
  wire [3:0]   accumulator;
  nci_flags_t  flags;
  int          error_cnt, checked, seed = 32'h10f4, pc, acc, addr, tgt, i;

  nci_instr_exec nci_instr_exec_i (.clock, .sys_rst, .instrWord, .instrValid,
    .instrReady, .intRequest, .intAck, .returnDone, .waitExitEnableBits,
    .waitExitEvents, .programCounter, .accumulator, .flags, .intEnabled,
    .waitMode, .foreignInstr);

  // Free running clock
  initial forever #5 clock = ~clock;

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // One instruction, bounded wait for ready
  task automatic exec(logic [15:0] w);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (instrReady !== 1'b1) begin
      error_cnt++;
      end_of_test;
    end else begin
      instrWord = w;
      instrValid = 1;
      @(negedge clock);
      instrValid = 0;
      instrWord = $random(seed);
      @(negedge clock);
    end
  endtask : exec

  initial begin
    {instrValid, returnDone, waitExitEnableBits, instrWord} = '0;
    {intRequest, sys_rst, waitExitEvents} = 6'h3f;
    repeat (8) @(negedge clock);
    sys_rst = 0;
    for (i = 0; i < 4; i++) begin
      @(negedge clock);
      chk("ack_off", intAck, 0);
    end
    intRequest = 0;
    // Memory is not reset: preload the nibble under test and model it
    addr = $random(seed) & 127;
    acc = $random(seed) & 15;
    nci_instr_exec_i.u_dmem.mem[addr] = acc[3:0];
    pc = 0;
    for (i = 0; i < 20; i++) begin
      exec(`NCI_INC_VAL | addr);
      acc = (acc + 1) & 15;
      pc = (pc + 1) & 2047;
      chk("acc", accumulator, acc);
      chk("flags", flags, {acc == 0, acc == 0});
      chk("known_inc", foreignInstr, 0);
      tgt = $random(seed) & 2047;
      exec(`NCI_JB0_VAL | tgt);
      pc = acc[0] ? tgt : (pc + 1) & 2047;
      chk("pc_jb0", programCounter, pc);
      tgt = $random(seed) & 2047;
      exec(`NCI_JB1_VAL | tgt);
      pc = acc[1] ? tgt : (pc + 1) & 2047;
      chk("pc_jb1", programCounter, pc);
    end
    // A bit-2 jump lies outside the subset: no jump, flagged foreign
    tgt = $random(seed) & 2047;
    exec(16'ha000 | tgt);
    pc = (pc + 1) & 2047;
    chk("pc_other", programCounter, pc);
    chk("foreign", foreignInstr, 1);
    exec(`NCI_OP_EN_INT);
    pc = (pc + 1) & 2047;
    chk("int_en", intEnabled, 1);
    exec(`NCI_OP_HOLD);
    pc = (pc + 1) & 2047;
    chk("wait", waitMode, 1);
    chk("ready", instrReady, 0);
    waitExitEnableBits = 4'h5;
    waitExitEvents = 4'ha;
    repeat (3) @(negedge clock);
    chk("wait_kept", waitMode, 1);
    chk("pc_halt", programCounter, pc);
    waitExitEvents = 4'h4;
    @(negedge clock);
    chk("wait_rel", waitMode, 0);
    waitExitEvents = 0;
    exec(`NCI_OP_HOLD);
    intRequest = 1;
    @(negedge clock);
    chk("ack", intAck, 1);
    chk("wait_int", waitMode, 0);
    intRequest = 0;
    repeat (3) @(negedge clock);
    returnDone = 1;
    @(negedge clock);
    returnDone = 0;
    chk("wait_back", waitMode, 1);
    chk("ready_back", instrReady, 0);
    // Reset again in mid-run: interrupts refused, memory kept
    sys_rst = 1;
    intRequest = 1;
    @(negedge clock);
    chk("rst_int", intEnabled, 0);
    sys_rst = 0;
    @(negedge clock);
    chk("ack_rst", intAck, 0);
    intRequest = 0;
    tgt = $random(seed) & 2047;
    exec(`NCI_JB0_VAL | tgt);
    chk("pc_rst", programCounter, 1);
    exec(`NCI_INC_VAL | addr);
    acc = (acc + 1) & 15;
    chk("acc_rst", accumulator, acc);
    end_of_test;
  end
endmodule : tb_top
